// ==== rstctl_pkg.sv ====
// Constants, register map and state encoding for the reset controller
package rstctl_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] STATUS_OFFSET = 8'h00;
  localparam logic [7:0] CONTROL_OFFSET = 8'h04;
  localparam logic [7:0] STRAPS_OFFSET = 8'h08;
  localparam logic [7:0] CFG_WORD_OFFSET = 8'h0c;
  localparam logic [7:0] DEFAULT_CFG_OFFSET = 8'h10;
  localparam logic [7:0] STATE_OFFSET = 8'h14;

  // ==========================================================
  // Status bit positions
  localparam int STAT_POR_BIT = 0;
  localparam int STAT_EXT_HARD_BIT = 1;
  localparam int STAT_EXT_SOFT_BIT = 2;
  localparam int STAT_WATCHDOG_BIT = 3;
  localparam int STAT_BUS_MONITOR_BIT = 4;
  localparam int STAT_HOST_BIT = 5;
  localparam int STAT_WIDTH = 6;

  // Control bit positions
  localparam int CTRL_BUS_MONITOR_EN_BIT = 0;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;

  // ==========================================================
  // Strap layout
  localparam int STRAP_WIDTH = 14;
  localparam int STRAP_CONFIG_MODE_BIT = 0;
  localparam int STRAP_CONFIG_SOURCE_BIT = 1;
  localparam int STRAP_SLAVE_SYNC_BIT = 2;
  localparam int STRAP_SLAVE_WIDTH_BIT = 3;
  localparam int STRAP_DEVICE_ID_LSB = 4;
  localparam int STRAP_BOOT_MODE_LSB = 8;
  localparam int STRAP_WATCHDOG_EN_BIT = 11;
  localparam int STRAP_CLOCK_MODE_LSB = 12;
  localparam logic [STRAP_WIDTH-1:0] STRAP_RESET = 14'h0000;

  // ==========================================================
  // Configuration word
  localparam logic [31:0] CFG_WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] DEFAULT_CFG_RESET = 32'h0000_0000;

  // ==========================================================
  // Timing in input-clock ticks; DRIVE_SETTLE in reference-clock cycles
  localparam int TICK_DIV = 2;
  localparam int TIMER_WIDTH = 11;
  localparam logic [TIMER_WIDTH-1:0] POR_DELAY_TICKS = 11'h400;
  localparam logic [TIMER_WIDTH-1:0] HARD_RELEASE_TICKS = 11'h200;
  localparam logic [TIMER_WIDTH-1:0] SOFT_RELEASE_TICKS = 11'h203;
  localparam int DRIVE_SETTLE = 3;

  // ==========================================================
  // Sequencer states
  typedef enum logic [5:0] {
    ST_POR = 6'b000001,
    ST_POR_DELAY = 6'b000010,
    ST_PLL_WAIT = 6'b000100,
    ST_HARD = 6'b001000,
    ST_SOFT = 6'b010000,
    ST_RUN = 6'b100000
  } rst_state_e;

endpackage

// ==== rst_sync.sv ====
// Two flip-flop synchroniser for a group of external reset pins
`timescale 1ns/1ps
`default_nettype none
module rst_sync #(
  parameter int WIDTH = 3
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // ==========================================================
  // One synchroniser per pin; pins idle high
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      always_ff @(posedge mclk_i)
      begin
        if (rst_i)
        begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
        end
        else
        begin
          meta_q[g] <= async_i[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_q;
endmodule // rst_sync
`default_nettype wire

// ==== tick_timer.sv ====
// Saturating counter of divider ticks with a programmable terminal count
`timescale 1ns/1ps
`default_nettype none
module tick_timer
  import rstctl_pkg::*;
#(
  parameter logic [TIMER_WIDTH-1:0] LIMIT = POR_DELAY_TICKS
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic tick_i,
  output logic [TIMER_WIDTH-1:0] count_o,
  output logic done_o
);
  logic [TIMER_WIDTH-1:0] count_q;

  // ==========================================================
  // Count up to LIMIT and hold there
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || clear_i)
      count_q <= '0;
    else if (tick_i && count_q != LIMIT)
      count_q <= count_q + 11'h001;
  end

  assign count_o = count_q;
  assign done_o = (count_q == LIMIT);
endmodule // tick_timer
`default_nettype wire

// ==== reset_controller.sv ====
// Multi-source reset sequencer with AHB-Lite status and configuration registers
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RULE_01) Power-on resets everything, PLL, drives both lines
// (RULE_02) Mode straps configured only during power-on reset
// (RULE_03) Soft line driven whenever hard line driven
// (RULE_04) Hard line open-drain, only pulled low
// (RULE_05) Hard reset drives lines, reapplies configuration word
// (RULE_06) External soft seen only while not resetting
// (RULE_07) Soft reset resets cores, keeps configuration
// (RULE_08) Enabled watchdog expiry starts hard sequence
// (RULE_09) Enabled bus monitor expiry starts hard sequence
// (RULE_10) Host command starts internal soft sequence
// (RULE_11) Status register records latest reset sources
// (RULE_12) Straps, PLL, slave-port write: power-on only
// (RULE_13) System-bus config write on power-on or hard
// (RULE_14) All resets hit buses; interface on hard
// (RULE_15) Board holds power-on low sixteen clocks
// (RULE_16) Configuration via slave port or system bus
// (RULE_17) Slave without written word gets default
// (RULE_18) Fourteen straps latched at power-on release
// (RULE_19) Internal power-on ends 1024 clocks later
// (RULE_20) Hard line released 512 clocks after lock
// (RULE_21) Soft line released 515 clocks after lock
// (RULE_22) External pins synchronised, sources set status
module reset_controller (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic power_on_reset_n_i,
  input wire logic hard_reset_n_i,
  output logic hard_reset_n_o,
  output logic hard_reset_oe_o,
  input wire logic soft_reset_n_i,
  output logic soft_reset_n_o,
  output logic soft_reset_oe_o,
  input wire logic watchdog_expired_i,
  input wire logic bus_monitor_expired_i,
  input wire logic host_reset_cmd_i,
  input wire logic system_pll_locked_i,
  input wire logic [rstctl_pkg::STRAP_WIDTH-1:0] straps_i,
  input wire logic slave_cfg_valid_i,
  input wire logic [31:0] slave_cfg_data_i,
  input wire logic sysbus_cfg_valid_i,
  input wire logic [31:0] sysbus_cfg_data_i,
  output logic slave_cfg_window_o,
  output logic sysbus_cfg_window_o,
  output logic [31:0] cfg_word_o,
  output logic internal_por_o,
  output logic system_pll_reset_o,
  output logic core_reset_o,
  output logic peripheral_bus_reset_o,
  output logic shared_memory_bus_reset_o,
  output logic system_interface_reset_o,
  output logic config_mode_strap_o,
  output logic config_source_strap_o,
  output logic slave_sync_strap_o,
  output logic slave_width_strap_o,
  output logic [3:0] device_select_id_o,
  output logic [2:0] boot_mode_strap_o,
  output logic watchdog_enable_strap_o,
  output logic [1:0] clock_mode_strap_o
);
  import rstctl_pkg::*;

  // ==========================================================
  // Declarations
  logic [2:0] pins_s;
  logic por_n_s;
  logic hard_n_s;
  logic soft_n_s;
  logic por_n_prev_q;
  logic [1:0] div_q;
  logic tick;
  rst_state_e state_q;
  rst_state_e state_d;
  logic state_change;
  logic [TIMER_WIDTH-1:0] por_count;
  logic por_done;
  logic [TIMER_WIDTH-1:0] lock_count;
  logic lock_done;
  logic drive_hard;
  logic drive_soft;
  logic [DRIVE_SETTLE-1:0] hard_hist_q;
  logic [DRIVE_SETTLE-1:0] soft_hist_q;
  logic ext_hard_evt;
  logic ext_soft_evt;
  logic wdog_evt;
  logic bmon_evt;
  logic hard_evt;
  logic soft_evt;
  logic [STAT_WIDTH-1:0] status_q;
  logic [STAT_WIDTH-1:0] src_bits;
  logic [31:0] control_q;
  logic [STRAP_WIDTH-1:0] strap_q;
  logic [31:0] cfg_word_q;
  logic [31:0] cfg_pend_q;
  logic cfg_seen_q;
  logic [31:0] default_cfg_q;
  logic por_flow;
  logic flow_end;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic addr_phase;

  // Register read decode, shared by the bus read path
  function automatic logic [31:0] read_mux(input logic [7:0] addr,
                                           input logic [STAT_WIDTH-1:0] stat,
                                           input logic [31:0] ctrl,
                                           input logic [STRAP_WIDTH-1:0] strap,
                                           input logic [31:0] cfg,
                                           input logic [31:0] dflt,
                                           input logic [5:0] st);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (addr)
      STATUS_OFFSET: r = {26'h0, stat};
      CONTROL_OFFSET: r = ctrl;
      STRAPS_OFFSET: r = {18'h0, strap};
      CFG_WORD_OFFSET: r = cfg;
      DEFAULT_CFG_OFFSET: r = dflt;
      STATE_OFFSET: r = {26'h0, st};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Pin synchronisation
  rst_sync #(
    .WIDTH(3)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i({soft_reset_n_i, hard_reset_n_i, power_on_reset_n_i}),
    .sync_o(pins_s)
  ); // RULE_22

  assign por_n_s = pins_s[0];
  assign hard_n_s = pins_s[1];
  assign soft_n_s = pins_s[2];

  // ==========================================================
  // Input-clock tick divider; the reference clock runs at twice the rate
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || div_q == 2'(TICK_DIV - 1))
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  end

  assign tick = (div_q == 2'(TICK_DIV - 1));

  // ==========================================================
  // Timers
  tick_timer #(
    .LIMIT(POR_DELAY_TICKS)
  ) u_por_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clear_i(state_q != ST_POR_DELAY),
    .tick_i(tick),
    .count_o(por_count),
    .done_o(por_done)
  ); // RULE_19

  // Ticks only count once the PLL reports lock
  tick_timer #(
    .LIMIT(SOFT_RELEASE_TICKS)
  ) u_lock_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clear_i(state_change),
    .tick_i(tick && system_pll_locked_i),
    .count_o(lock_count),
    .done_o(lock_done)
  ); // RULE_21

  // ==========================================================
  // Source detection
  // Own drive echoes through the synchroniser;
  // trust a line only after the settle window
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      hard_hist_q <= '1;
      soft_hist_q <= '1;
    end
    else
    begin
      hard_hist_q <= {hard_hist_q[DRIVE_SETTLE-2:0], drive_hard};
      soft_hist_q <= {soft_hist_q[DRIVE_SETTLE-2:0], drive_soft};
    end
  end

  assign ext_hard_evt = !hard_n_s && !drive_hard && (hard_hist_q == '0) && (state_q == ST_RUN || state_q == ST_SOFT);
  assign ext_soft_evt = !soft_n_s && !drive_soft && (soft_hist_q == '0) && (state_q == ST_RUN); // RULE_06
  assign wdog_evt = watchdog_expired_i && strap_q[STRAP_WATCHDOG_EN_BIT]; // RULE_08
  assign bmon_evt = bus_monitor_expired_i && control_q[CTRL_BUS_MONITOR_EN_BIT]; // RULE_09
  assign hard_evt = (ext_hard_evt || wdog_evt || bmon_evt) && (state_q == ST_RUN || state_q == ST_SOFT);
  assign soft_evt = (ext_soft_evt || host_reset_cmd_i) && (state_q == ST_RUN); // RULE_10

  always_comb
  begin
    src_bits = '0;
    src_bits[STAT_EXT_HARD_BIT] = ext_hard_evt;
    src_bits[STAT_WATCHDOG_BIT] = wdog_evt;
    src_bits[STAT_BUS_MONITOR_BIT] = bmon_evt;
    src_bits[STAT_EXT_SOFT_BIT] = ext_soft_evt && !hard_evt;
    src_bits[STAT_HOST_BIT] = host_reset_cmd_i && !hard_evt && state_q == ST_RUN;
  end

  // ==========================================================
  // Sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_POR:
        if (por_n_s)
          state_d = ST_POR_DELAY;
      ST_POR_DELAY:
        if (por_done)
          state_d = ST_PLL_WAIT; // RULE_19
      ST_PLL_WAIT, ST_HARD, ST_SOFT:
        if (hard_evt && state_q == ST_SOFT)
          state_d = ST_HARD;
        else if (lock_done)
          state_d = ST_RUN; // RULE_21
      ST_RUN:
        if (hard_evt)
          state_d = ST_HARD; // RULE_08 RULE_09
        else if (soft_evt)
          state_d = ST_SOFT; // RULE_10
      default:
        state_d = ST_POR;
    endcase
    if (!por_n_s)
      state_d = ST_POR; // RULE_01
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      state_q <= ST_POR;
    else
      state_q <= state_d;
  end

  assign state_change = (state_d != state_q);
  assign por_flow = (state_q == ST_POR) || (state_q == ST_POR_DELAY) || (state_q == ST_PLL_WAIT);
  assign flow_end = (state_q != ST_RUN) && (state_d == ST_RUN);

  // ==========================================================
  // Reset outputs
  assign drive_hard = (state_q == ST_POR) || (state_q == ST_POR_DELAY) ||
                      ((state_q == ST_PLL_WAIT || state_q == ST_HARD) && lock_count < HARD_RELEASE_TICKS); // RULE_20 RULE_14
  assign drive_soft = drive_hard || (state_q != ST_RUN); // RULE_03 RULE_07
  assign hard_reset_n_o = 1'b0; // RULE_04
  assign hard_reset_oe_o = drive_hard; // RULE_04 RULE_05
  assign soft_reset_n_o = 1'b0;
  assign soft_reset_oe_o = drive_soft; // RULE_07
  assign internal_por_o = (state_q == ST_POR) || (state_q == ST_POR_DELAY); // RULE_19
  assign system_pll_reset_o = internal_por_o; // RULE_01 RULE_12
  assign core_reset_o = (state_q != ST_RUN); // RULE_14
  assign peripheral_bus_reset_o = (state_q != ST_RUN); // RULE_14
  assign shared_memory_bus_reset_o = (state_q != ST_RUN); // RULE_14
  assign system_interface_reset_o = por_flow || (state_q == ST_HARD); // RULE_14

  // ==========================================================
  // Strap capture on the synchronised power-on release edge
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      por_n_prev_q <= 1'b0;
    else
      por_n_prev_q <= por_n_s;
  end

  // Straps bypass the two-stage delay of the pin, so the board must
  // hold them a few clocks past the release edge
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      strap_q <= STRAP_RESET;
    else if (por_n_s && !por_n_prev_q)
      strap_q <= straps_i; // RULE_18 RULE_02 RULE_12
  end

  assign config_mode_strap_o = strap_q[STRAP_CONFIG_MODE_BIT];
  assign config_source_strap_o = strap_q[STRAP_CONFIG_SOURCE_BIT];
  assign slave_sync_strap_o = strap_q[STRAP_SLAVE_SYNC_BIT];
  assign slave_width_strap_o = strap_q[STRAP_SLAVE_WIDTH_BIT]; // RULE_02
  assign device_select_id_o = strap_q[STRAP_DEVICE_ID_LSB +: 4];
  assign boot_mode_strap_o = strap_q[STRAP_BOOT_MODE_LSB +: 3];
  assign watchdog_enable_strap_o = strap_q[STRAP_WATCHDOG_EN_BIT];
  assign clock_mode_strap_o = strap_q[STRAP_CLOCK_MODE_LSB +: 2];

  // ==========================================================
  // Reset configuration word
  assign slave_cfg_window_o = por_flow; // RULE_12 RULE_16
  assign sysbus_cfg_window_o = por_flow || (state_q == ST_HARD); // RULE_13 RULE_16

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || (state_change && (state_d == ST_POR || state_d == ST_HARD)))
    begin
      cfg_seen_q <= 1'b0;
      cfg_pend_q <= CFG_WORD_RESET;
    end
    else if (slave_cfg_valid_i && slave_cfg_window_o)
    begin
      cfg_seen_q <= 1'b1;
      cfg_pend_q <= slave_cfg_data_i; // RULE_12
    end
    else if (sysbus_cfg_valid_i && sysbus_cfg_window_o)
    begin
      cfg_seen_q <= 1'b1;
      cfg_pend_q <= sysbus_cfg_data_i; // RULE_13
    end
  end

  // Applied at the end of a power-on or hard flow; soft flows keep it
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      cfg_word_q <= CFG_WORD_RESET;
    else if (flow_end && state_q != ST_SOFT)
    begin
      if (cfg_seen_q)
        cfg_word_q <= cfg_pend_q; // RULE_05
      else if (strap_q[STRAP_CONFIG_SOURCE_BIT])
        cfg_word_q <= default_cfg_q; // RULE_17
    end
  end

  assign cfg_word_o = cfg_word_q;

  // ==========================================================
  // AHB-Lite slave, zero wait states, always OKAY
  assign addr_phase = hsel_i && htrans_i[1] && hready_i;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= addr_phase && hwrite_i;
      wr_addr_q <= haddr_i[7:0];
      if (addr_phase && !hwrite_i)
        hrdata_q <= read_mux(haddr_i[7:0], status_q, control_q, strap_q, cfg_word_q, default_cfg_q, state_q);
    end
  end

  assign hrdata_o = hrdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // ==========================================================
  // Status: a new reset replaces the record, and beats a same-cycle clear
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      status_q <= '0;
    else if (state_change && state_d == ST_POR)
      status_q <= 6'h01; // RULE_11
    else if (state_change && (state_d == ST_HARD || state_d == ST_SOFT))
      status_q <= src_bits; // RULE_11 RULE_22
    else if (wr_pend_q && wr_addr_q == STATUS_OFFSET)
      status_q <= status_q & ~hwdata_i[STAT_WIDTH-1:0];
  end

  // Control lives in the system interface and returns to CONTROL_RESET on hard resets
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || system_interface_reset_o)
      control_q <= CONTROL_RESET; // RULE_14
    else if (wr_pend_q && wr_addr_q == CONTROL_OFFSET)
      control_q <= {31'h0, hwdata_i[CTRL_BUS_MONITOR_EN_BIT]};
  end

  // Default word must survive hard resets to be applied by them
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      default_cfg_q <= DEFAULT_CFG_RESET;
    else if (wr_pend_q && wr_addr_q == DEFAULT_CFG_OFFSET)
      default_cfg_q <= hwdata_i;
  end

endmodule // reset_controller
`default_nettype wire

// ==== reset_controller_props.sv ====
// Checker of reset sequencing seen at the controller ports
`timescale 1ns/1ps
`default_nettype none
module reset_controller_props (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic power_on_reset_n_i,
  input wire logic hard_reset_n_o,
  input wire logic hard_reset_oe_o,
  input wire logic soft_reset_oe_o,
  input wire logic watchdog_expired_i,
  input wire logic host_reset_cmd_i,
  input wire logic system_pll_locked_i,
  input wire logic slave_cfg_window_o,
  input wire logic sysbus_cfg_window_o,
  input wire logic internal_por_o,
  input wire logic system_pll_reset_o,
  input wire logic core_reset_o,
  input wire logic peripheral_bus_reset_o,
  input wire logic shared_memory_bus_reset_o,
  input wire logic system_interface_reset_o,
  input wire logic watchdog_enable_strap_o,
  input wire logic [3:0] device_select_id_o,
  input wire logic [2:0] boot_mode_strap_o,
  input wire logic [1:0] clock_mode_strap_o
);
  // ==========
  // Cycle counters; each bound spans seven cycles of slack
  logic [11:0] por_len_q;
  logic [11:0] lock_len_q;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !internal_por_o || !power_on_reset_n_i)
      por_len_q <= 12'h000;
    else
      por_len_q <= por_len_q + 12'h001;
  end
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !hard_reset_oe_o)
      lock_len_q <= 12'h000;
    else if (!internal_por_o && system_pll_locked_i)
      lock_len_q <= lock_len_q + 12'h001;
  end
  // ==========
  // Properties
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence soft_tail_s;
    soft_reset_oe_o[*4] ##[1:4] !soft_reset_oe_o;
  endsequence
  hard_soft_a: assert property (hard_reset_oe_o |-> soft_reset_oe_o)
    else $error("hard without soft");
  open_drain_a: assert property (hard_reset_oe_o |-> !hard_reset_n_o)
    else $error("hard driven high");
  por_all_a: assert property (internal_por_o |-> hard_reset_oe_o && core_reset_o && system_pll_reset_o)
    else $error("por flow incomplete");
  straps_hold_a: assert property (!internal_por_o |->
    $stable({device_select_id_o, boot_mode_strap_o, clock_mode_strap_o, watchdog_enable_strap_o}))
    else $error("straps changed");
  slave_win_a: assert property ($rose(slave_cfg_window_o) |-> internal_por_o)
    else $error("slave window open");
  sysbus_win_a: assert property ($rose(sysbus_cfg_window_o) |-> hard_reset_oe_o)
    else $error("bus window open");
  bus_reset_a: assert property (soft_reset_oe_o |-> core_reset_o && peripheral_bus_reset_o
    && shared_memory_bus_reset_o)
    else $error("units not reset");
  sysif_hard_a: assert property ($rose(system_interface_reset_o) |-> hard_reset_oe_o)
    else $error("interface reset");
  wdog_start_a: assert property (!core_reset_o && watchdog_enable_strap_o && watchdog_expired_i
    |=> hard_reset_oe_o)
    else $error("watchdog ignored");
  host_start_a: assert property (!core_reset_o && host_reset_cmd_i |=> soft_reset_oe_o)
    else $error("host ignored");
  por_len_a: assert property ($fell(internal_por_o) |-> por_len_q inside {[2048:2054]})
    else $error("por length");
  hard_len_a: assert property ($fell(hard_reset_oe_o) |-> lock_len_q inside {[1021:1027]})
    else $error("hard release time");
  soft_gap_a: assert property ($fell(hard_reset_oe_o) |-> soft_tail_s)
    else $error("soft release time");
endmodule // reset_controller_props
bind reset_controller reset_controller_props props_u (.*);
`default_nettype wire

// ==== board_model.sv ====
// Board supervisor: power-on pin, open-drain pulls, PLL lock and straps
`timescale 1ns/1ps
`default_nettype none
module board_model #(
  parameter int LOCK_DLY = 40
) (
  input wire logic mclk_i,
  input wire logic por_req_i,
  input wire logic hard_req_i,
  input wire logic soft_req_i,
  input wire logic pll_reset_i,
  input wire logic [13:0] strap_val_i,
  output logic power_on_reset_n_o = 1'b0,
  output logic hard_pull_o = 1'b0,
  output logic soft_pull_o = 1'b0,
  output logic system_pll_locked_o = 1'b0,
  output logic [13:0] straps_o = 14'h0000
);
  int low_q = 0, hold_q = 0, lock_q = 0;
  // ==========
  // Slow PLL lock so the timer must wait for it
  always @(posedge mclk_i)
  begin
    low_q <= por_req_i ? 0 : low_q + 1;
    power_on_reset_n_o <= (low_q >= 16);
    hold_q <= power_on_reset_n_o ? hold_q + 1 : 0;
    straps_o <= (hold_q < 8) ? strap_val_i : ~strap_val_i;
    hard_pull_o <= hard_req_i;
    soft_pull_o <= soft_req_i;
    lock_q <= pll_reset_i ? 0 : lock_q + 1;
    system_pll_locked_o <= (lock_q >= LOCK_DLY);
  end
endmodule // board_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the reset controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rstctl_pkg::*;
  localparam logic [13:0] STRAPS = 14'h2f52;
  localparam logic [31:0] DFLT = 32'h5a5a_0003;
  logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, cfg_word, bdata = '0, q;
  logic [1:0] htrans = '0;
  logic por_req = 1'b1, hard_req = 1'b0, soft_req = 1'b0, wdog = 1'b0, busmon = 1'b0, host = 1'b0;
  logic svalid = 1'b0, bvalid = 1'b0, hard_oe, soft_oe, hard_n, soft_n, hard_pull, soft_pull;
  logic por_n, locked, pll_rst, sys_win;
  logic [13:0] straps, so;
  wire hard_line = !((hard_oe && !hard_n) || hard_pull);
  wire soft_line = !((soft_oe && !soft_n) || soft_pull);
  int n_fail = 0, check_count = 0, cyc = 0;
  always #2 mclk = ~mclk;
  board_model model_u (.mclk_i(mclk), .por_req_i(por_req), .hard_req_i(hard_req), .soft_req_i(soft_req),
    .pll_reset_i(pll_rst), .strap_val_i(STRAPS), .power_on_reset_n_o(por_n), .hard_pull_o(hard_pull),
    .soft_pull_o(soft_pull), .system_pll_locked_o(locked), .straps_o(straps));
  reset_controller dut_u (.mclk_i(mclk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .power_on_reset_n_i(por_n), .hard_reset_n_i(hard_line),
    .hard_reset_n_o(hard_n), .hard_reset_oe_o(hard_oe), .soft_reset_n_i(soft_line), .soft_reset_n_o(soft_n),
    .soft_reset_oe_o(soft_oe), .watchdog_expired_i(wdog), .bus_monitor_expired_i(busmon),
    .host_reset_cmd_i(host), .system_pll_locked_i(locked), .straps_i(straps), .slave_cfg_valid_i(svalid),
    .slave_cfg_data_i(bdata), .sysbus_cfg_valid_i(bvalid), .sysbus_cfg_data_i(bdata),
    .slave_cfg_window_o(), .sysbus_cfg_window_o(sys_win), .cfg_word_o(cfg_word), .internal_por_o(),
    .system_pll_reset_o(pll_rst), .core_reset_o(), .peripheral_bus_reset_o(),
    .shared_memory_bus_reset_o(), .system_interface_reset_o(), .config_mode_strap_o(so[0]),
    .config_source_strap_o(so[1]), .slave_sync_strap_o(so[2]), .slave_width_strap_o(so[3]),
    .device_select_id_o(so[7:4]), .boot_mode_strap_o(so[10:8]), .watchdog_enable_strap_o(so[11]),
    .clock_mode_strap_o(so[13:12]));
  // ==========
  // Shared tasks
  task automatic wrap_up();
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Waits bounded; a hang shows up as one mismatch
  task automatic wait_oe(input logic sel_hard, input logic lvl);
    int n = 0;
    while (((sel_hard ? hard_oe : soft_oe) !== lvl) && n < 4000)
    begin
      @(posedge mclk);
      n++;
    end
    chk(sel_hard ? hard_oe : soft_oe, lvl);
  endtask
  // ==========
  // Scenarios
  task automatic t_por();
    bus(1'b1, DEFAULT_CFG_OFFSET, DFLT, q);
    chk(hresp, 1'b0);
    rdc(CONTROL_OFFSET, CONTROL_RESET);
    chk({hard_oe, soft_oe}, 2'b11);
    wait_oe(1'b1, 1'b0);
    chk(soft_oe, 1'b1);
    wait_oe(1'b0, 1'b0);
    rdc(STATUS_OFFSET, 32'h01);
    rdc(STRAPS_OFFSET, {18'h0, STRAPS});
    chk(so, STRAPS);
    chk(cfg_word, DFLT);
    rdc(STATE_OFFSET, 32'h20);
    rdc(8'h40, 32'h0);
  endtask
  task automatic t_hard();
    hard_req <= 1'b1;
    wait_oe(1'b1, 1'b1);
    hard_req <= 1'b0;
    chk({soft_oe, sys_win}, 2'b11);
    bvalid <= 1'b1;
    bdata <= 32'hc0de_0001;
    @(posedge mclk);
    bvalid <= 1'b0;
    wait_oe(1'b0, 1'b0);
    chk(cfg_word, 32'hc0de_0001);
    rdc(STATUS_OFFSET, 32'h02);
    rdc(STRAPS_OFFSET, {18'h0, STRAPS});
  endtask
  task automatic t_internal();
    wdog <= 1'b1;
    @(posedge mclk);
    wdog <= 1'b0;
    wait_oe(1'b1, 1'b1);
    wait_oe(1'b0, 1'b0);
    rdc(STATUS_OFFSET, 32'h08);
    chk(cfg_word, DFLT);
    bus(1'b1, CONTROL_OFFSET, 32'h0, q);
    rdc(CONTROL_OFFSET, 32'h0);
    busmon <= 1'b1;
    @(posedge mclk);
    busmon <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(soft_oe, 1'b0);
    bus(1'b1, CONTROL_OFFSET, 32'h1, q);
    busmon <= 1'b1;
    @(posedge mclk);
    busmon <= 1'b0;
    wait_oe(1'b1, 1'b1);
    wait_oe(1'b0, 1'b0);
    rdc(STATUS_OFFSET, 32'h10);
  endtask
  task automatic t_soft();
    host <= 1'b1;
    @(posedge mclk);
    host <= 1'b0;
    soft_req <= 1'b1;
    bvalid <= 1'b1;
    svalid <= 1'b1;
    bdata <= 32'h0000_0bad;
    wait_oe(1'b0, 1'b1);
    bvalid <= 1'b0;
    svalid <= 1'b0;
    repeat (20) @(posedge mclk);
    chk({hard_oe, sys_win}, 2'b00);
    soft_req <= 1'b0;
    wait_oe(1'b0, 1'b0);
    chk(cfg_word, DFLT);
    rdc(STATUS_OFFSET, 32'h20);
    soft_req <= 1'b1;
    wait_oe(1'b0, 1'b1);
    soft_req <= 1'b0;
    wait_oe(1'b0, 1'b0);
    rdc(STATUS_OFFSET, 32'h04);
    bus(1'b1, STATUS_OFFSET, 32'h04, q);
    rdc(STATUS_OFFSET, 32'h0);
  endtask
  // ==========
  // Sequence and hang guard
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    por_req <= 1'b0;
    t_por();
    t_hard();
    t_internal();
    t_soft();
    wrap_up();
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end
endmodule // testbench
`default_nettype wire
